// ===== hdl/cbr_device.sv
// The implementer's own choice: the two-wire serial link port.
`default_nettype none
// Contract
// - target only, block read and write
// - early stop keeps completed bytes
// - address 1101 plus latched strap bits
// - write: index, count, data, all acked
// - read: index, restart, count then data
// - host nacks last read byte, stops
// - byte0 gate bits 6,4,3,1 reset 1
// - gate 0 forces selected disabled level
// - byte1 bits 7:6 show bandwidth strap
// - byte1 bit5 picks mode source
// - software mode bits need bit5 set
// - byte1 bits 1:0 amplitude, reset 10
// - byte2 edge bits 6,4,3,1 reset 1
// - byte3 bit5 frequency select enable
// - code acts only while enabled
// - byte3 bit0 feedback edge, reset 1
// - disabled level code, reset low/low
module cbr_device
	import cbr_pkg::*;
(
	input  wire logic       i_ref_clk,              // system clock
	input  wire logic       i_reset,                // sync reset
	cbr_smbus_if.device     bus,                    // serial link
	input  wire logic [2:0] i_address_select_strap, // low address bits
	input  wire logic [1:0] i_bandwidth_strap,      // pll mode strap
	input  wire logic [3:0] i_output_enable_n,      // per-output enable pins
	output logic      [3:0] o_output_run,           // output toggling
	output logic      [3:0] o_edge_rate,            // 1 fast, 0 slow
	output logic            o_park_true,            // disabled true level
	output logic            o_park_comp,            // disabled comp level
	output logic            o_park_hiz,             // disabled pair floats
	output logic      [1:0] o_pll_mode,             // effective pll mode
	output logic      [1:0] o_swing_level,          // amplitude code
	output logic            o_feedback_edge_rate,   // 1 fast, 0 slow
	output logic            o_frequency_sw_enable,  // software freq select
	output logic      [1:0] o_frequency_code        // effective freq code
);
	// ****************************************
	// state
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_INDEX, S_COUNT, S_WDATA, S_TX
	} cbr_dev_state_t;

	typedef struct packed {
		logic           scl_s1, scl_s2, scl_d;  // clock synchroniser
		logic           sda_s1, sda_s2, sda_d;  // data synchroniser
		logic [3:0]     oe_s1, oe_s2;           // enable pin sync
		logic [2:0]     adr_s1, adr_lat;        // address strap
		logic [1:0]     bw_s1, bw_lat;          // bandwidth strap
		cbr_dev_state_t state;                  // byte-level phase
		logic [3:0]     cnt;                    // bit within byte
		logic [7:0]     shift;                  // rx/tx byte
		logic [7:0]     index;                  // register index
		logic [7:0]     remain;                 // write bytes left
		logic           ack_ok;                 // continue after slot
		logic           cnt_sent;               // count byte gone
		logic           drv;                    // pull data low
		logic [7:0]     gate, pll, slew, freq;  // registers 0..3
		logic [1:0]     park;                   // disabled level code
		logic [3:0]     run, edge_o;            // output copies
		logic           pt, pc, ph;             // park levels
		logic [1:0]     mode, swing, fcode;
		logic           fb, fen;
	} cbr_dev_t;

	cbr_dev_t st;       // registered state
	cbr_dev_t next_st;  // next state

	// ****************************************
	// link events
	// ****************************************
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = st.scl_s2 & ~st.scl_d;
	assign scl_fall = ~st.scl_s2 & st.scl_d;
	// data falls while clock high: start or repeated start
	assign start_c  = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
	assign stop_c   = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;

	// register read view
	function automatic logic [7:0] rd_byte(input cbr_dev_t s);
		logic [7:0] r;
		r = 8'h00;
		case (s.index)
			IDX_GATE: r = s.gate;                  // reserved read 0
			IDX_PLL:  r = {s.bw_lat, s.pll[5:0]};  // strap readback
			IDX_EDGE: r = s.slew;                  // reserved read 1
			IDX_FREQ: r = s.freq;
			IDX_PARK: r = PARK_FIX | {6'h00, s.park};
			default:  r = 8'h00;                   // unmapped index
		endcase
		return r;
	endfunction : rd_byte

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		// two-flop synchronisers
		next_st.scl_s1 = bus.scl;
		next_st.scl_s2 = st.scl_s1;
		next_st.scl_d  = st.scl_s2;
		next_st.sda_s1 = bus.sda;
		next_st.sda_s2 = st.sda_s1;
		next_st.sda_d  = st.sda_s2;
		next_st.oe_s1  = i_output_enable_n;
		next_st.oe_s2  = st.oe_s1;
		next_st.adr_s1 = i_address_select_strap;
		next_st.bw_s1  = i_bandwidth_strap;
		if (start_c) begin
			// start aborts anything, keeps written bytes
			next_st.state = S_ADDR;
			next_st.cnt   = 4'h0;
			next_st.drv   = 1'b0;
		end else if (stop_c) begin
			// stop may end any transfer
			next_st.state = S_IDLE;
			next_st.cnt   = 4'h0;
			next_st.drv   = 1'b0;
		end else if (st.state != S_IDLE) begin
			if (scl_rise) begin
				if (st.cnt < BIT_ACK) begin
					if (st.state != S_TX) begin
						next_st.shift = {st.shift[6:0], st.sda_s2};
					end
					next_st.cnt = st.cnt + 4'h1;
				end else if (st.cnt == BIT_ACK) begin
					next_st.cnt = BIT_END;
					// host ack continues, nack ends the read
					if (st.state == S_TX) begin
						next_st.ack_ok = ~st.sda_s2;
					end
				end
			end
			if (scl_fall) begin
				if (st.cnt == BIT_ACK) begin
					next_st.drv = 1'b1;   // acknowledge the byte
					case (st.state)
						S_ADDR: begin
							// fixed high bits plus strap
							if (st.shift[7:1] == {ADDR_FIXED, st.adr_lat}) begin
								next_st.ack_ok   = 1'b1;
								next_st.cnt_sent = 1'b0;
								// direction bit picks read or write
								next_st.state    = st.shift[0] ? S_TX : S_INDEX;
							end else begin
								next_st.drv   = 1'b0;      // not ours
								next_st.state = S_IDLE;
							end
						end
						S_INDEX: begin
							next_st.index = st.shift;      // start index
							next_st.state = S_COUNT;
						end
						S_COUNT: begin
							next_st.remain = st.shift;     // byte count
							next_st.state  = S_WDATA;
						end
						S_WDATA: begin
							next_st.index = st.index + 8'h01;
							if (st.remain != 8'h00) begin
								next_st.remain = st.remain - 8'h01;
								// masked writes keep fixed bits
								case (st.index)
									IDX_GATE: next_st.gate =
										(st.gate & ~GATE_WM) | (st.shift & GATE_WM);
									IDX_PLL:  next_st.pll =
										(st.pll & ~PLL_WM) | (st.shift & PLL_WM);
									IDX_EDGE: next_st.slew =
										(st.slew & ~EDGE_WM) | (st.shift & EDGE_WM);
									IDX_FREQ: next_st.freq =
										(st.freq & ~FREQ_WM) | (st.shift & FREQ_WM);
									IDX_PARK: next_st.park = st.shift[1:0];
									default:  next_st.park = st.park;  // ignored
								endcase
							end
						end
						default: next_st.drv = 1'b0;  // tx: free slot for host
					endcase
				end else if (st.cnt == BIT_END) begin
					next_st.drv = 1'b0;
					next_st.cnt = 4'h0;
					if (st.state == S_TX) begin
						if (st.ack_ok) begin
							// count first, then data from index
							if (st.cnt_sent) begin
								next_st.shift = rd_byte(st);
								next_st.index = st.index + 8'h01;
								next_st.drv   = ~next_st.shift[7];
							end else begin
								next_st.shift = RD_COUNT;
								next_st.drv   = ~RD_COUNT[7];
							end
							next_st.cnt_sent = 1'b1;
						end else begin
							next_st.state = S_IDLE;  // nack: wait for stop
						end
					end
				end else if (st.state == S_TX && st.cnt != 4'h0) begin
					// present next bit, msb first
					next_st.shift = {st.shift[6:0], 1'b0};
					next_st.drv   = ~st.shift[6];
				end
			end
		end
		// ****************************************
		// output decode
		// ****************************************
		for (int i = 0; i < 4; i++) begin
			// gate 0 overrides the pin
			next_st.run[i]    = st.gate[OUT_POS[i]] & ~st.oe_s2[i];
			next_st.edge_o[i] = st.slew[OUT_POS[i]];
		end
		case (st.park)
			PARK_HIZ:      {next_st.pt, next_st.pc, next_st.ph} = 3'h1;
			PARK_HIGH_LOW: {next_st.pt, next_st.pc, next_st.ph} = 3'h4;
			PARK_LOW_HIGH: {next_st.pt, next_st.pc, next_st.ph} = 3'h2;
			default:       {next_st.pt, next_st.pc, next_st.ph} = 3'h0;
		endcase
		// software mode only with select set
		next_st.mode  = st.pll[PLL_SW_BIT] ? st.pll[PLL_SW_LSB +: 2] : st.bw_lat;
		next_st.swing = st.pll[SWING_LSB +: 2];
		next_st.fen   = st.freq[FREQ_EN_BIT];
		// code gated by the enable
		next_st.fcode = st.freq[FREQ_EN_BIT] ? st.freq[FREQ_LSB +: 2] : 2'h0;
		next_st.fb    = st.freq[FB_EDGE_BIT];
		// ****************************************
		// reset: constants, straps caught
		// ****************************************
		if (i_reset) begin
			next_st        = '0;
			// link syncs rest at the idle level, no false edge
			{next_st.scl_s1, next_st.scl_s2, next_st.scl_d} = 3'h7;
			{next_st.sda_s1, next_st.sda_s2, next_st.sda_d} = 3'h7;
			next_st.adr_s1 = i_address_select_strap;
			next_st.bw_s1  = i_bandwidth_strap;
			next_st.adr_lat = st.adr_s1;   // latched at power-up
			next_st.bw_lat  = st.bw_s1;    // latched at power-up
			next_st.gate   = GATE_RST;
			next_st.pll    = PLL_RST;
			next_st.slew   = EDGE_RST;
			next_st.freq   = FREQ_RST;
			next_st.park   = PARK_RST;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk) begin
		st <= next_st;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign bus.dev_sda_o          = 1'b0;
	assign bus.dev_sda_oe_n       = ~st.drv;
	assign o_output_run           = st.run;
	assign o_edge_rate            = st.edge_o;
	assign o_park_true            = st.pt;
	assign o_park_comp            = st.pc;
	assign o_park_hiz             = st.ph;
	assign o_pll_mode             = st.mode;
	assign o_swing_level          = st.swing;
	assign o_feedback_edge_rate   = st.fb;
	assign o_frequency_sw_enable  = st.fen;
	assign o_frequency_code       = st.fcode;
endmodule : cbr_device
`default_nettype wire

// ===== hdl/cbr_pkg.sv
`default_nettype none
package cbr_pkg;
	// ****************************************
	// target address and link timing
	// ****************************************
	localparam logic [3:0] ADDR_FIXED     = 4'hD;   // upper four address bits
	localparam int unsigned CLK_PERIOD_NS = 4;      // i_ref_clk period
	localparam int unsigned LINK_PERIOD_NS = 160;   // serial clock period
	localparam int unsigned QUARTER_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS / 4;
	localparam logic [3:0]  BIT_ACK       = 4'h8;   // ack slot of a byte
	localparam logic [3:0]  BIT_END       = 4'h9;   // ack slot seen high
	localparam int unsigned MAX_BYTES     = 4;      // host data buffer bytes
	// ****************************************
	// register indexes
	// ****************************************
	localparam logic [7:0] IDX_GATE = 8'h00;        // output_gate_enables
	localparam logic [7:0] IDX_PLL  = 8'h01;        // pll_mode_and_amplitude
	localparam logic [7:0] IDX_EDGE = 8'h02;        // output_edge_rate_select
	localparam logic [7:0] IDX_FREQ = 8'h03;        // frequency_select_control
	localparam logic [7:0] IDX_PARK = 8'h0B;        // disabled level control
	localparam logic [7:0] RD_COUNT = 8'h04;        // count byte sent on reads
	// ****************************************
	// reset values and writable masks
	// ****************************************
	localparam logic [7:0] GATE_RST = 8'h5A;
	localparam logic [7:0] GATE_WM  = 8'h5A;
	localparam logic [7:0] PLL_RST  = 8'h06;
	localparam logic [7:0] PLL_WM   = 8'h3B;
	localparam logic [7:0] EDGE_RST = 8'hFF;
	localparam logic [7:0] EDGE_WM  = 8'h5A;
	localparam logic [7:0] FREQ_RST = 8'hC7;
	localparam logic [7:0] FREQ_WM  = 8'h39;
	localparam logic [7:0] PARK_FIX = 8'h40;        // fixed upper bits of index 11
	localparam logic [1:0] PARK_RST = 2'h0;
	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned OUT_POS [4] = '{1, 3, 4, 6}; // per-output bit
	localparam int unsigned PLL_SW_BIT  = 5;
	localparam int unsigned PLL_SW_LSB  = 3;
	localparam int unsigned SWING_LSB   = 0;
	localparam int unsigned FREQ_EN_BIT = 5;
	localparam int unsigned FREQ_LSB    = 3;
	localparam int unsigned FB_EDGE_BIT = 0;
	// ****************************************
	// disabled level codes
	// ****************************************
	localparam logic [1:0] PARK_LOW_LOW  = 2'h0;
	localparam logic [1:0] PARK_HIZ      = 2'h1;
	localparam logic [1:0] PARK_HIGH_LOW = 2'h2;
	localparam logic [1:0] PARK_LOW_HIGH = 2'h3;
endpackage : cbr_pkg
`default_nettype wire

// ===== hdl/cbr_smbus_if.sv
`default_nettype none
// ****************************************
// two-wire link, open-drain data
// ****************************************
interface cbr_smbus_if;
	logic scl;            // serial clock, driven by host
	logic host_sda_o;     // host data value, always low
	logic host_sda_oe_n;  // host pulls data low when low
	logic dev_sda_o;      // device data value, always low
	logic dev_sda_oe_n;   // device pulls data low when low
	logic sda;            // resolved wire level
	// wired-and with pull-up
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
	modport host   (output scl, host_sda_o, host_sda_oe_n, input sda);
	modport device (input scl, sda, output dev_sda_o, dev_sda_oe_n);
endinterface : cbr_smbus_if
`default_nettype wire

// ===== hdl/cbr_host.sv
`default_nettype none
module cbr_host
	import cbr_pkg::*;
#(
	parameter int unsigned QUARTER = QUARTER_CYCLES  // clocks per quarter bit
) (
	input  wire logic        i_ref_clk,     // system clock
	input  wire logic        i_reset,       // sync reset
	cbr_smbus_if.host        bus,           // serial link
	input  wire logic        i_start,       // begin transfer, pulse
	input  wire logic        i_write,       // 1 write, 0 read
	input  wire logic [6:0]  i_target_addr, // device address
	input  wire logic [7:0]  i_index,       // start index
	input  wire logic [7:0]  i_count,       // bytes, up to four
	input  wire logic [31:0] i_wdata,       // byte k at [8k+7:8k]
	output logic             o_busy,        // transfer running
	output logic             o_done,        // one-cycle end pulse
	output logic             o_addr_nack,   // address not acked
	output logic      [7:0]  o_rcount,      // count byte returned
	output logic      [31:0] o_rdata        // bytes read, byte k at 8k
);
	// ****************************************
	// state
	// ****************************************
	typedef enum logic [3:0] {
		H_IDLE, H_START, H_ADDR_W, H_INDEX, H_COUNT, H_WDATA,
		H_RSTART, H_ADDR_R, H_RCOUNT, H_RDATA, H_STOP
	} cbr_host_state_t;

	typedef struct packed {
		cbr_host_state_t state;  // symbol being sent
		logic [7:0]  q;          // quarter timer
		logic [1:0]  ph;         // quarter within bit
		logic [3:0]  bitn;       // bit within byte
		logic [7:0]  shift;      // tx/rx byte
		logic [7:0]  k;          // data byte number
		logic        scl, low;   // clock out, pull data low
		logic        sda_s1, sda_s2;
		logic        wr, busy, done, nack;
		logic [6:0]  addr;
		logic [7:0]  index, count, rcount;
		logic [31:0] wdata, rdata;
	} cbr_host_t;

	cbr_host_t st;       // registered state
	cbr_host_t next_st;  // next state

	logic tick, is_tx, ack_now, last;
	assign tick    = st.q == 8'(QUARTER - 1);
	assign is_tx   = st.state inside {H_ADDR_W, H_INDEX, H_COUNT, H_WDATA, H_ADDR_R};
	assign last    = (st.k + 8'h01) >= st.count;
	// ack all but the final read byte
	assign ack_now = (st.state == H_RCOUNT) ? (st.count != 8'h00) : ~last;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st        = st;
		next_st.sda_s1 = bus.sda;
		next_st.sda_s2 = st.sda_s1;
		next_st.done   = 1'b0;
		if (st.state == H_IDLE) begin
			next_st.scl = 1'b1;
			next_st.low = 1'b0;
			if (i_start) begin
				next_st.state = H_START;
				next_st.q     = 8'h00;
				next_st.ph    = 2'h0;
				next_st.busy  = 1'b1;
				next_st.nack  = 1'b0;
				next_st.wr    = i_write;
				next_st.addr  = i_target_addr;
				next_st.index = i_index;
				next_st.count = i_count;
				next_st.wdata = i_wdata;
			end
		end else if (!tick) begin
			next_st.q = st.q + 8'h01;
		end else begin
			next_st.q  = 8'h00;
			next_st.ph = st.ph + 2'h1;
			case (st.ph)
				2'h0: next_st.scl = 1'b0;
				2'h1: begin
					// data changes only while clock low
					if (st.state == H_STOP) begin
						next_st.low = 1'b1;
					end else if (st.state == H_START || st.state == H_RSTART) begin
						next_st.low = 1'b0;
					end else if (st.bitn == BIT_ACK) begin
						next_st.low = is_tx ? 1'b0 : ack_now;
					end else begin
						next_st.low = is_tx ? ~st.shift[7] : 1'b0;
					end
				end
				2'h2: next_st.scl = 1'b1;
				default: begin
					next_st.bitn = 4'h0;
					case (st.state)
						H_START, H_RSTART: begin
							next_st.low   = 1'b1;  // start while clock high
							next_st.shift = {st.addr, st.state == H_RSTART};
							next_st.state = (st.state == H_START) ? H_ADDR_W : H_ADDR_R;
						end
						H_STOP: begin
							next_st.low   = 1'b0;  // stop while clock high
							next_st.state = H_IDLE;
							next_st.busy  = 1'b0;
							next_st.done  = 1'b1;
						end
						default: begin
							if (st.bitn != BIT_ACK) begin
								next_st.shift = {st.shift[6:0], st.sda_s2};
								next_st.bitn  = st.bitn + 4'h1;
							end else begin
								next_st.k = 8'h00;
								case (st.state)
									H_ADDR_W: begin
										next_st.nack  = st.sda_s2;
										next_st.shift = st.index;
										next_st.state = st.sda_s2 ? H_STOP : H_INDEX;
									end
									// write sends count, read restarts
									H_INDEX: begin
										next_st.shift = st.count;
										next_st.state = st.wr ? H_COUNT : H_RSTART;
									end
									H_COUNT: begin
										next_st.shift = st.wdata[7:0];
										next_st.state = (st.count == 8'h00) ? H_STOP : H_WDATA;
									end
									H_WDATA: begin
										next_st.k     = st.k + 8'h01;
										next_st.wdata = {8'h00, st.wdata[31:8]};
										next_st.shift = st.wdata[15:8];
										next_st.state = last ? H_STOP : H_WDATA;
									end
									H_ADDR_R: begin
										next_st.nack  = st.sda_s2;
										next_st.state = st.sda_s2 ? H_STOP : H_RCOUNT;
									end
									H_RCOUNT: begin
										next_st.rcount = st.shift;
										next_st.state  = (st.count == 8'h00) ? H_STOP : H_RDATA;
									end
									default: begin
										next_st.rdata[{st.k[1:0], 3'h0} +: 8] = st.shift;
										next_st.k     = st.k + 8'h01;
										next_st.state = last ? H_STOP : H_RDATA;
									end
								endcase
							end
						end
					endcase
				end
			endcase
		end
		if (i_reset) begin
			next_st     = '0;
			next_st.scl = 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk) begin
		st <= next_st;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign bus.scl           = st.scl;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_sda_oe_n = ~st.low;
	assign o_busy            = st.busy;
	assign o_done            = st.done;
	assign o_addr_nack       = st.nack;
	assign o_rcount          = st.rcount;
	assign o_rdata           = st.rdata;
endmodule : cbr_host
`default_nettype wire

// ===== sim/cbr_link_sva.sv
`default_nettype none
// ****
// link checks
// ****
module cbr_link_sva #(
	parameter int unsigned QUARTER = 4 // clocks per quarter bit
) (
	input wire logic i_ref_clk,     // system clock
	input wire logic i_reset,       // sync reset
	input wire logic scl,           // serial clock
	input wire logic host_sda_o,    // host data value
	input wire logic host_sda_oe_n, // host pull, low active
	input wire logic dev_sda_o,     // device data value
	input wire logic dev_sda_oe_n,  // device pull, low active
	input wire logic sda            // resolved wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_q;   // scl one clock ago
	logic [7:0] run_len; // clocks at current scl level
	// level length counter, saturating
	always_ff @(posedge i_ref_clk) begin
		scl_q   <= scl;
		run_len <= (i_reset || scl != scl_q) ? 8'h01 : run_len + {7'h00, run_len != 8'hFF};
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	// start and stop edges on the wire
	sequence start_seen;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_seen;
		scl && $past(scl) && $rose(sda);
	endsequence
	host_low_a: assert property (host_sda_o == 1'b0)
		else $error("host data value not low");
	dev_low_a: assert property (dev_sda_o == 1'b0)
		else $error("device data value not low");
	dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("device moved data while clock high");
	dev_late_turn_a: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2))
		else $error("device turned data too soon");
	idle_rst_a: assert property ($fell(i_reset) |-> scl && sda)
		else $error("link not idle after reset");
	phase_len_a: assert property (scl != scl_q |-> run_len >= QUARTER)
		else $error("clock level too short");
	host_start_a: assert property (start_seen |-> !host_sda_oe_n && dev_sda_oe_n)
		else $error("start not made by host");
	stop_free_a: assert property (stop_seen |=> dev_sda_oe_n [*4])
		else $error("device pulls data after stop");
endmodule : cbr_link_sva
`default_nettype wire

// ===== sim/test_smbus_clock_buffer_config_regs.sv
`default_nettype none
module test_smbus_clock_buffer_config_regs
	import cbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// bench signals
	// ****
	localparam logic [2:0] ASEL = 3'h5;                // address strap
	localparam logic [1:0] BWS  = 2'h2;                // bandwidth strap
	localparam logic [6:0] DADR = {4'hD, ASEL};        // device address
	logic        i_ref_clk = 1'b0;                     // system clock
	logic        i_reset   = 1'b1;                     // sync reset
	logic        start     = 1'b0;                     // host start pulse
	logic        wr        = 1'b0;                     // 1 write
	logic [6:0]  taddr     = 7'h00;                    // target address
	logic [7:0]  idx       = 8'h00;                    // start index
	logic [7:0]  cnt       = 8'h00;                    // byte count
	logic [31:0] wdata     = 32'h0000_0000;            // write bytes
	logic [3:0]  oe_n      = 4'h5;                     // enable pins
	logic        busy, done, anack, fb, fen, pt, pc, pz;
	logic [7:0]  rcount;
	logic [31:0] rdata;
	logic [3:0]  run, edg;
	logic [1:0]  mode, swing, code;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc       = 0;
	cbr_smbus_if link ();
	cbr_host #(.QUARTER(4)) i_cbr_host (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.bus(link.host), .i_start(start), .i_write(wr), .i_target_addr(taddr), .i_index(idx),
		.i_count(cnt), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_addr_nack(anack),
		.o_rcount(rcount), .o_rdata(rdata));
	cbr_device i_cbr_device (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .bus(link.device),
		.i_address_select_strap(ASEL), .i_bandwidth_strap(BWS), .i_output_enable_n(oe_n),
		.o_output_run(run), .o_edge_rate(edg), .o_park_true(pt), .o_park_comp(pc),
		.o_park_hiz(pz), .o_pll_mode(mode), .o_swing_level(swing), .o_feedback_edge_rate(fb),
		.o_frequency_sw_enable(fen), .o_frequency_code(code));
	cbr_link_sva #(.QUARTER(4)) i_cbr_link_sva (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.scl(link.scl), .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));
	always #2 i_ref_clk = ~i_ref_clk;
	// hang guard
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			report_and_stop();
		end
	end
	// ****
	// tasks
	// ****
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one host transfer, waits for the end pulse
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] i,
			input logic [7:0] n, input logic [31:0] d);
		int k;
		@(posedge i_ref_clk);
		start <= 1'b1;
		wr    <= w;
		taddr <= a;
		idx   <= i;
		cnt   <= n;
		wdata <= d;
		@(posedge i_ref_clk);
		start <= 1'b0;
		@(posedge i_ref_clk);
		chk(32'(busy), 32'h1);
		for (k = 0; k < 3000 && done !== 1'b1; k++)
			@(posedge i_ref_clk);
		chk(32'(k < 3000), 32'h1);
		repeat (4) @(posedge i_ref_clk);
	endtask : xfer
	task automatic t_reset();
		xfer(1'b0, DADR, 8'h00, 8'h04, 32'h0000_0000);
		chk(rdata, {8'hC7, 8'hFF, BWS, 6'h06, 8'h5A});
		chk(rcount, 8'h04);
		chk({run, edg, mode, swing, fb, fen, code, pt, pc, pz}, {4'hA, 4'hF, BWS, 2'h2, 7'h40});
		$display("test reset done");
	endtask : t_reset
	task automatic t_addr();
		int b;
		for (b = 0; b < 7; b++) begin
			xfer(1'b1, DADR ^ 7'(1 << b), 8'h02, 8'h01, 32'h0000_0000);
			chk(anack, 1'b1);
		end
		xfer(1'b0, DADR, 8'h02, 8'h01, 32'h0000_0000);
		chk({anack, rdata[7:0]}, {1'b0, 8'hFF});
		$display("test address done");
	endtask : t_addr
	task automatic t_modes();
		logic [1:0] m;
		for (int k = 0; k < 4; k++) begin
			m = k[1:0];
			xfer(1'b1, DADR, 8'h00, 8'h04, {3'h1, m, 2'h0, m[0], {4{m}}, 2'h3, 1'b1, m, 1'b0, m, 8'hFF});
			xfer(1'b0, DADR, 8'h00, 8'h04, 32'h0000_0000);
			chk(rdata, {3'h7, m, 2'h3, m[0], 1'b1, m[0], 1'b1, m[0], m[1], 1'b1, m[1], 1'b1,
				BWS, 1'b1, m, 1'b1, m, 8'h5A});
			chk({edg, mode, swing, fen, code, fb}, {m[0], m[0], m[1], m[1], m, m, 1'b1, m, m[0]});
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_source();
		xfer(1'b1, DADR, 8'h01, 8'h01, 32'h0000_0018);
		xfer(1'b1, DADR, 8'h03, 8'h01, 32'h0000_0018);
		chk({mode, swing, fen, code, fb}, {BWS, 6'h00});
		xfer(1'b0, DADR, 8'h01, 8'h02, 32'h0000_0000);
		chk(rdata[15:0], {8'hFF, BWS, 6'h1C});
		$display("test source done");
	endtask : t_source
	task automatic t_park();
		logic [2:0] tbl [4];
		tbl = '{3'h0, 3'h1, 3'h4, 3'h2};
		xfer(1'b1, DADR, 8'h00, 8'h01, 32'h0000_0000);
		for (int c = 0; c < 4; c++) begin
			xfer(1'b1, DADR, 8'h0B, 8'h01, {30'h0000_0000, 2'(c)});
			chk({run, pt, pc, pz}, {4'h0, tbl[c]});
		end
		$display("test park done");
	endtask : t_park
	// ****
	// main sequence
	// ****
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		t_reset();
		t_addr();
		t_modes();
		t_source();
		t_park();
		report_and_stop();
	end
endmodule : test_smbus_clock_buffer_config_regs
`default_nettype wire
